// *** rtc_i2c_target.sv ***
// Two-wire target port of the clock: framing, pointer, carry hold, release
`timescale 1ns/1ps
module rtc_i2c_target #(
    parameter int unsigned RELEASE_CYC = rtc_i2c_pkg::RELEASE_CYC_DEF
) (
    input  wire logic                 sys_clk_in,
    input  wire logic                 rst_in,
    input  wire logic                 scl_in,
    input  wire logic                 sda_in,
    output      logic                 sda_out,
    output      logic                 sda_oe_n_out,
    output      logic [3:0]           reg_addr_out,
    input  wire logic [7:0]           reg_rdata_in,
    output      rtc_i2c_pkg::reg_wr_t reg_wr_out,
    output      logic                 reg_wr_valid_out,
    input  wire logic                 carry_tick_in,
    output      logic                 carry_tick_out,
    output      logic                 carry_hold_out
);
    import rtc_i2c_pkg::*;

    // ************************************************************
    // Elaboration check
    // ************************************************************
    // The timer is 24 bits wide; a count of one would release at once
    if (RELEASE_CYC < 2 || RELEASE_CYC > 32'h00FF_FFFF) begin : g_chk
        $error("RELEASE_CYC out of range");
    end

    localparam logic [23:0] RELEASE_LAST = 24'(RELEASE_CYC - 1);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic        scl_m;
    logic        scl_s;
    logic        scl_d;
    logic        sda_m;
    logic        sda_s;
    logic        sda_d;
    logic        scl_rise;
    logic        scl_fall;
    logic        start;
    logic        stop;
    logic        open;
    logic        released;
    logic [23:0] timer;
    logic        release_now;
    logic        pending;
    logic        hold;
    phase_t      state;
    logic [3:0]  cnt;
    logic [7:0]  shift;
    logic [1:0]  byte_idx;
    logic        is_read;
    logic        fast;
    logic        host_ack;
    logic        sda_low;
    logic [3:0]  ptr;
    reg_wr_t     wr;
    logic        wr_valid;
    logic [7:0]  tx_byte;

    // ************************************************************
    // Pin synchronisers and condition detection
    // ************************************************************
    // Two stages per pin, a third stage only for edge detection
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= sda_in;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    // Edges of SCL; start and stop need SCL high on both samples
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start    = scl_s & scl_d & sda_d & ~sda_s;
    assign stop     = scl_s & scl_d & ~sda_d & sda_s;

    // ************************************************************
    // Access window and forced release
    // ************************************************************
    // Release fires once, on the last cycle of the window
    assign release_now = open & ~released & (timer == RELEASE_LAST);

    // Timer runs from the first start only; repeated starts leave it
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            open     <= 1'b0;
            released <= 1'b0;
            timer    <= 24'h00_0000;
        end else if (stop) begin
            open     <= 1'b0;
            released <= 1'b0;
            timer    <= 24'h00_0000;
        end else if (start && !open) begin
            open     <= 1'b1;
            released <= 1'b0;
            timer    <= 24'h00_0000;
        end else if (release_now) begin
            released <= 1'b1;
        end else if (open && !released) begin
            timer    <= timer + 24'h00_0001;
        end
    end

    // ************************************************************
    // Carry hold
    // ************************************************************
    assign hold = open & ~released;

    // Carries seen during an access merge into one; the hold ends after
    // at most RELEASE_MS, half a second, so no second carry can be lost
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pending        <= 1'b0;
            carry_tick_out <= 1'b0;
        end else begin
            carry_tick_out <= ~hold & (carry_tick_in | pending);
            pending        <= hold & (carry_tick_in | pending);
        end
    end

    // ************************************************************
    // Byte engine
    // ************************************************************
    // Released access reads as all ones instead of register contents
    assign tx_byte = released ? READ_IDLE : reg_rdata_in;

    // SDA is sampled on SCL rise and driven on SCL fall
    always_ff @(posedge sys_clk_in) begin
        wr_valid <= 1'b0;
        if (rst_in) begin
            state    <= ST_IDLE;
            cnt      <= 4'h0;
            shift    <= 8'h00;
            byte_idx <= 2'h0;
            is_read  <= 1'b0;
            fast     <= 1'b0;
            host_ack <= 1'b0;
            sda_low  <= 1'b0;
            ptr      <= PTR_STOP;
            wr       <= '0;
        end else if (stop || release_now) begin
            state   <= ST_IDLE;
            sda_low <= 1'b0;
            ptr     <= PTR_STOP;
        end else if (start) begin
            state    <= ST_RX;
            cnt      <= 4'h0;
            byte_idx <= 2'h0;
            is_read  <= 1'b0;
            fast     <= 1'b0;
            sda_low  <= 1'b0;
        end else begin
            case (state)
                ST_RX: begin
                    if (scl_rise) begin
                        shift <= {shift[6:0], sda_s};
                        cnt   <= cnt + 4'h1;
                    end else if (scl_fall && cnt == BYTE_BITS) begin
                        cnt   <= 4'h0;
                        state <= ST_RX_ACK;
                        if (byte_idx != 2'h2) begin
                            byte_idx <= byte_idx + 2'h1;
                        end
                        if (byte_idx == 2'h0) begin
                            if (shift[7:1] == TARGET_ADDR) begin
                                sda_low <= 1'b1;
                                is_read <= shift[0];
                            end else begin
                                state <= ST_WAIT;
                            end
                        end else if (byte_idx == 2'h1) begin
                            ptr     <= shift[PTR_MSB:PTR_LSB];
                            fast    <= (shift[FMT_MSB:FMT_LSB] == FMT_FAST);
                            sda_low <= ~released;
                        end else begin
                            sda_low <= ~released;
                            if (!released) begin
                                wr_valid <= 1'b1;
                                wr       <= '{addr: ptr, data: shift};
                                ptr      <= ptr + 4'h1;
                            end
                        end
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        // Read address and fast format both turn around
                        if (is_read || fast) begin
                            state   <= ST_TX;
                            shift   <= tx_byte;
                            sda_low <= ~tx_byte[7];
                        end else begin
                            state   <= ST_RX;
                            sda_low <= 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (cnt == TX_LAST_BIT) begin
                            state   <= ST_TX_ACK;
                            sda_low <= 1'b0;
                            cnt     <= 4'h0;
                            ptr     <= ptr + 4'h1;
                        end else begin
                            cnt     <= cnt + 4'h1;
                            shift   <= {shift[6:0], 1'b0};
                            sda_low <= ~shift[6];
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        host_ack <= ~sda_s;
                    end else if (scl_fall) begin
                        if (host_ack) begin
                            state   <= ST_TX;
                            shift   <= tx_byte;
                            sda_low <= ~tx_byte[7];
                        end else begin
                            state   <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    sda_low <= 1'b0;
                end
                ST_IDLE: begin
                    sda_low <= 1'b0;
                end
                default: begin
                    state   <= ST_IDLE;
                    sda_low <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Open drain: only ever drives low, enable active low
    assign sda_out          = 1'b0;
    assign sda_oe_n_out     = ~sda_low;
    assign reg_addr_out     = ptr;
    assign reg_wr_out       = wr;
    assign reg_wr_valid_out = wr_valid;
    assign carry_hold_out   = hold;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence addr_done_s;
        state == ST_RX && scl_fall && cnt == BYTE_BITS &&
            byte_idx == 2'h0 && !release_now;
    endsequence

    sequence fast_turn_s;
        state == ST_RX_ACK && fast && scl_fall && !release_now;
    endsequence

    sequence wdata_done_s;
        state == ST_RX && scl_fall && cnt == BYTE_BITS &&
            byte_idx == 2'h2 && !release_now;
    endsequence

    start_opens_a: assert property (
        start && !open && !stop |=> open && timer == 24'h00_0000)
        else $error("Start did not open the access");

    idle_stays_a: assert property (
        state == ST_IDLE && !start |=> state == ST_IDLE)
        else $error("Engine left idle without start");

    addr_ack_a: assert property (
        addr_done_s and shift[7:1] == TARGET_ADDR
        |=> sda_low && state == ST_RX_ACK)
        else $error("Matching address not acknowledged");

    addr_miss_a: assert property (
        addr_done_s and shift[7:1] != TARGET_ADDR
        |=> !sda_low && state == ST_WAIT)
        else $error("Foreign address not ignored");

    stop_ptr_a: assert property (
        stop |=> ptr == PTR_STOP && state == ST_IDLE)
        else $error("Stop did not reset pointer");

    force_rel_a: assert property (
        release_now && !stop
        |=> released && ptr == PTR_STOP && !carry_hold_out)
        else $error("Forced release incomplete");

    restart_keep_a: assert property (
        start && open && !released && !stop && !release_now
        |=> timer == $past(timer) + 24'h00_0001)
        else $error("Repeated start disturbed timer");

    rel_nack_a: assert property (
        wdata_done_s and released |=> !sda_low && !reg_wr_valid_out)
        else $error("Write acknowledged after release");

    wr_store_a: assert property (
        wdata_done_s and !released
        |=> sda_low && reg_wr_valid_out && reg_wr_out.data == $past(shift))
        else $error("Write byte not stored or acknowledged");

    ptr_wrap_a: assert property (
        reg_wr_valid_out && reg_wr_out.addr == 4'hF |-> ptr == 4'h0)
        else $error("Pointer did not wrap");

    tx_release_a: assert property (
        state == ST_TX_ACK |-> !sda_low)
        else $error("SDA held during acknowledge slot");

    fast_turn_a: assert property (
        fast_turn_s |=> state == ST_TX && sda_low == !$past(tx_byte[7]))
        else $error("Fast format did not transmit");

    carry_defer_a: assert property (
        carry_tick_in && carry_hold_out |=> !carry_tick_out && pending)
        else $error("Carry passed during access");

    carry_apply_a: assert property (
        pending && !carry_hold_out |=> carry_tick_out ##1 !pending)
        else $error("Deferred carry not applied");

endmodule

// *** rtc_i2c_pkg.sv ***
// Constants and types shared by the two-wire target port of the clock
package rtc_i2c_pkg;

    // ************************************************************
    // Bus addressing and byte layout
    // ************************************************************
    localparam logic [6:0] TARGET_ADDR = 7'h32;   // 0110010
    localparam logic [3:0] PTR_STOP    = 4'hF;
    localparam logic [3:0] FMT_WRITE   = 4'h0;
    localparam logic [3:0] FMT_FAST    = 4'h4;
    localparam logic [7:0] READ_IDLE   = 8'hFF;
    localparam int         PTR_MSB     = 7;
    localparam int         PTR_LSB     = 4;
    localparam int         FMT_MSB     = 3;
    localparam int         FMT_LSB     = 0;
    localparam logic [3:0] BYTE_BITS   = 4'h8;
    localparam logic [3:0] TX_LAST_BIT = 4'h7;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_KHZ         = 25000;
    localparam int RELEASE_MS      = 500;
    localparam int RELEASE_CYC_DEF = RELEASE_MS * CLK_KHZ;
    localparam int CARRY_US        = 61;
    localparam int CARRY_CYC       = (CARRY_US * CLK_KHZ) / 1000;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_RX     = 3'h1,
        ST_RX_ACK = 3'h3,
        ST_TX     = 3'h2,
        ST_TX_ACK = 3'h6,
        ST_WAIT   = 3'h7
    } phase_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] data;
    } reg_wr_t;

endpackage

// *** rtc_bus_host.sv ***
// Bus controller model for the two-wire link of the clock port
`timescale 1ns/1ps
module rtc_bus_host (
    input  wire logic sys_clk_in,
    input  wire logic sda_oe_n_in,
    output      logic scl_out,
    output      logic sda_out
);
    logic sda_low = 1'b0;

    // ************************************************************
    // Wire and bit timing
    // ************************************************************
    // Pull-up: a released line reads high, never the last value
    assign sda_out = sda_oe_n_in & ~sda_low;
    initial scl_out = 1'b1;

    // Wait n clocks, then change just after the edge
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    // Start or repeated start; SCL idles high only between frames
    task automatic start();
        wt(2);
        sda_low = 1'b0;
        wt(3);
        scl_out = 1'b1;
        wt(4);
        sda_low = 1'b1;
        wt(4);
        scl_out = 1'b0;
    endtask

    // Take SCL low with SDA high, so no condition is formed
    task automatic scl_low();
        wt(2);
        scl_out = 1'b0;
    endtask

    // Stop, then a quiet gap so held carries land first
    task automatic stop();
        wt(2);
        sda_low = 1'b1;
        wt(3);
        scl_out = 1'b1;
        wt(4);
        sda_low = 1'b0;
        wt(1600);
    endtask

    // 5 clocks low, 3 high; data moves only while SCL is low
    task automatic bit_x(input logic b, output logic r);
        wt(2);
        sda_low = ~b;
        wt(3);
        scl_out = 1'b1;
        wt(3);
        r = sda_out;
        scl_out = 1'b0;
    endtask

    // Byte out MSB first, then let go for the ninth clock
    task automatic put(input logic [7:0] b, output logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(b[i], r);
        bit_x(1'b1, nack);
    endtask

    // Byte in, then acknowledge when more is wanted
    task automatic get(input logic more, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
        bit_x(~more, r);
    endtask
endmodule

// *** testbench.sv ***
// Self-checking bench for the two-wire target port of the clock
`timescale 1ns/1ps
module testbench;
    import rtc_i2c_pkg::*;

    logic       sys_clk_in;
    logic       rst_in;
    logic       carry_tick_in;
    logic       scl, sda, sda_oe_n, sda_drv, wr_valid, tick_out, hold;
    logic [3:0] reg_addr_out;
    logic [7:0] reg_rdata_in;
    logic [7:0] mem [16];
    reg_wr_t    wr;
    int         miscompares   = 0;
    int         cmp_count     = 0;
    int         ticks         = 0;

    always #20 sys_clk_in = ~sys_clk_in;

    // Short release count keeps the run brief
    rtc_i2c_target #(.RELEASE_CYC(2000)) u_dut (
        .sys_clk_in       (sys_clk_in),
        .rst_in           (rst_in),
        .scl_in           (scl),
        .sda_in           (sda),
        .sda_out          (sda_drv),
        .sda_oe_n_out     (sda_oe_n),
        .reg_addr_out     (reg_addr_out),
        .reg_rdata_in     (reg_rdata_in),
        .reg_wr_out       (wr),
        .reg_wr_valid_out (wr_valid),
        .carry_tick_in    (carry_tick_in),
        .carry_tick_out   (tick_out),
        .carry_hold_out   (hold)
    );

    rtc_bus_host u_host (
        .sys_clk_in  (sys_clk_in),
        .sda_oe_n_in (sda_oe_n | sda_drv),
        .scl_out     (scl),
        .sda_out     (sda)
    );

    // ************************************************************
    // Register file stand-in and carry counter
    // ************************************************************
    assign reg_rdata_in = mem[reg_addr_out];
    always @(posedge sys_clk_in) begin
        if (wr_valid) begin
            mem[wr.addr] <= wr.data;
        end
        if (tick_out) begin
            ticks <= ticks + 1;
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Start plus own address, expecting the acknowledge
    task automatic open_acc(input logic rd);
        logic a;
        u_host.start();
        u_host.put({TARGET_ADDR, rd}, a);
        chk({7'h00, a}, 8'h00);
    endtask

    task automatic wr_b(input logic [7:0] b, input logic nack);
        logic a;
        u_host.put(b, a);
        chk({7'h00, a}, {7'h00, nack});
    endtask

    task automatic rd_b(input logic more, input logic [7:0] exp);
        logic [7:0] d;
        u_host.get(more, d);
        chk(d, exp);
    endtask

    task automatic close_acc();
        u_host.stop();
        chk({4'h0, reg_addr_out}, {4'h0, PTR_STOP});
        chk({7'h00, hold}, 8'h00);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_no_start();
        logic a;
        chk({7'h00, sda_oe_n}, 8'h01);
        u_host.scl_low();
        u_host.put({TARGET_ADDR, 1'b0}, a);
        chk({7'h00, a}, 8'h01);
        chk({7'h00, hold}, 8'h00);
    endtask

    task automatic t_bad_addr();
        logic a;
        u_host.start();
        u_host.put({TARGET_ADDR ^ 7'h01, 1'b0}, a);
        chk({7'h00, a}, 8'h01);
        wr_b(8'h20, 1'b1);
        close_acc();
    endtask

    task automatic t_plain();
        open_acc(1'b1);
        rd_b(1'b1, 8'h4F);
        rd_b(1'b0, 8'h40);
        close_acc();
    endtask

    task automatic t_pointed();
        open_acc(1'b0);
        wr_b({4'h2, FMT_WRITE}, 1'b0);
        open_acc(1'b1);
        rd_b(1'b1, 8'h42);
        rd_b(1'b0, 8'h43);
        close_acc();
    endtask

    // Fast format wraps past Fh, then stays silent after a refusal
    task automatic t_fast();
        open_acc(1'b0);
        wr_b({4'hE, FMT_FAST}, 1'b0);
        rd_b(1'b1, 8'h4E);
        rd_b(1'b1, 8'h4F);
        rd_b(1'b0, 8'h40);
        rd_b(1'b0, READ_IDLE);
        close_acc();
    endtask

    task automatic t_write();
        open_acc(1'b0);
        wr_b({4'hE, FMT_WRITE}, 1'b0);
        wr_b(8'h11, 1'b0);
        wr_b(8'h22, 1'b0);
        wr_b(8'h33, 1'b0);
        close_acc();
        chk(mem[4'hE], 8'h11);
        chk(mem[4'hF], 8'h22);
        chk(mem[4'h0], 8'h33);
    endtask

    task automatic t_carry();
        int t0;
        t0 = ticks;
        carry_tick_in = 1'b1;
        u_host.wt(1);
        carry_tick_in = 1'b0;
        u_host.wt(3);
        chk(8'(ticks - t0), 8'h01);
        open_acc(1'b0);
        carry_tick_in = 1'b1;
        u_host.wt(1);
        carry_tick_in = 1'b0;
        u_host.wt(4);
        chk({7'h00, hold}, 8'h01);
        chk(8'(ticks - t0), 8'h01);
        close_acc();
        chk(8'(ticks - t0), 8'h02);
    endtask

    // Repeated start midway must not push the release out
    task automatic t_release();
        open_acc(1'b0);
        u_host.wt(1200);
        open_acc(1'b0);
        chk({7'h00, hold}, 8'h01);
        u_host.wt(900);
        chk({7'h00, hold}, 8'h00);
        chk({4'h0, reg_addr_out}, {4'h0, PTR_STOP});
        wr_b(8'h30, 1'b1);
        open_acc(1'b1);
        rd_b(1'b0, READ_IDLE);
        open_acc(1'b0);
        wr_b(8'h30, 1'b1);
        wr_b(8'h55, 1'b1);
        chk(mem[4'h3], 8'h43);
        close_acc();
    endtask

    initial begin
        sys_clk_in    = 1'b0;
        rst_in        = 1'b1;
        carry_tick_in = 1'b0;
        for (int i = 0; i < 16; i++) begin
            mem[i] = 8'h40 + 8'(i);
        end
        repeat (5) @(posedge sys_clk_in);
        #1;
        rst_in = 1'b0;
        u_host.wt(4);
        t_no_start();
        t_bad_addr();
        t_plain();
        t_pointed();
        t_fast();
        t_write();
        t_carry();
        t_release();
        conclude();
    end
endmodule
